// File: iraos_pkg.sv
// =====================================================================
// shared constants and types for the ident read / osc select slice
package iraos_pkg;

    // =================================================================
    // command codes, taken with data_command_select low
    localparam logic [7:0] CMD_SOFT_RESET        = 8'h01;
    localparam logic [7:0] READ_MAKER_IDENT_CMD  = 8'hda;
    localparam logic [7:0] READ_VERSION_IDENT_CMD = 8'hdb;
    localparam logic [7:0] READ_DRIVER_IDENT_CMD = 8'hdc;
    localparam logic [7:0] SELECT_ONCHIP_OSC_CMD = 8'hb0;
    localparam logic [7:0] SELECT_OFFCHIP_OSC_CMD = 8'hb1;

    // =================================================================
    // answer bytes and field layout
    localparam logic [7:0] DUMMY_BYTE            = 8'h00;
    localparam int         VERSION_IDENT_MSB     = 7;
    localparam logic       VERSION_IDENT_MSB_VAL = 1'b1;
    localparam logic [7:0] VERSION_RANGE_LOW     = 8'h80;

    // identity values: arbitrary neutral defaults
    localparam logic [7:0] MAKER_IDENT_DEFAULT   = 8'h5a;
    localparam logic [6:0] VERSION_IDENT_DEFAULT = 7'h21;
    localparam logic [7:0] DRIVER_IDENT_DEFAULT  = 8'h3c;

    // =================================================================
    // reset values
    localparam logic       OFFCHIP_OSC_RESET     = 1'b0;
    localparam logic [7:0] DATA_OUT_RESET        = 8'h00;

    // =================================================================
    // types
    typedef struct packed {
        logic       data_command_select;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] data;
    } iraos_bus_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DUMMY = 2'b01,
        ST_IDENT = 2'b11
    } iraos_state_e;

    typedef enum logic [1:0] {
        SEL_MAKER   = 2'b00,
        SEL_VERSION = 2'b01,
        SEL_DRIVER  = 2'b10
    } iraos_sel_e;

endpackage

// File: iraos_rise_det.sv
`timescale 1ns/1ns
// =====================================================================
// rising edge detector for a strobe synchronous to sys_clk
module iraos_rise_det (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic level,
    output logic      rise
);
    import iraos_pkg::*;

    logic prev;
    logic next_prev;

    // track last level; idle high so reset to high
    always_comb begin
        next_prev = level;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev <= 1'b1;
        end else begin
            prev <= next_prev;
        end
    end

    // pulse on low to high
    assign rise = level & ~prev;

endmodule

// File: iraos_ident_osc.sv
`timescale 1ns/1ns
// =====================================================================
// command decode: ident reads and oscillator source select
module iraos_ident_osc #(
    parameter logic [7:0] MAKER_IDENT   = iraos_pkg::MAKER_IDENT_DEFAULT,
    parameter logic [6:0] VERSION_IDENT = iraos_pkg::VERSION_IDENT_DEFAULT,
    parameter logic [7:0] DRIVER_IDENT  = iraos_pkg::DRIVER_IDENT_DEFAULT
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire iraos_pkg::iraos_bus_s host,
    output logic [7:0]              data_out,
    output logic                    data_oe,
    output logic                    offchip_osc_sel
);
    import iraos_pkg::*;

    // =================================================================
    // strobe edges
    logic wr_rise;
    logic rd_rise;

    iraos_rise_det u_wr_edge (
        .sys_clk (sys_clk),
        .rst     (rst),
        .level   (host.wr_n),
        .rise    (wr_rise)
    );

    iraos_rise_det u_rd_edge (
        .sys_clk (sys_clk),
        .rst     (rst),
        .level   (host.rd_n),
        .rise    (rd_rise)
    );

    // command byte taken on write rise with select low
    logic       cmd_take;
    logic [7:0] cmd;
    assign cmd_take = wr_rise & ~host.data_command_select;
    assign cmd      = host.data;

    // =================================================================
    // ident read sequence
    iraos_state_e state;
    iraos_state_e next_state;
    iraos_sel_e   sel;
    iraos_sel_e   next_sel;

    // no power state gates decode, so all modes accept these
    always_comb begin
        next_state = state;
        next_sel   = sel;
        if (cmd_take) begin
            case (cmd)
                READ_MAKER_IDENT_CMD: begin
                    next_state = ST_DUMMY;
                    next_sel   = SEL_MAKER;
                end
                READ_VERSION_IDENT_CMD: begin
                    next_state = ST_DUMMY;
                    next_sel   = SEL_VERSION;
                end
                READ_DRIVER_IDENT_CMD: begin
                    next_state = ST_DUMMY;
                    next_sel   = SEL_DRIVER;
                end
                default: begin
                    next_state = ST_IDLE; // other command aborts
                end
            endcase
        end else if (rd_rise) begin
            case (state)
                ST_DUMMY: next_state = ST_IDENT; // dummy consumed
                ST_IDENT: next_state = ST_IDLE;
                default:  next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            sel   <= SEL_MAKER;
        end else begin
            state <= next_state;
            sel   <= next_sel;
        end
    end

    // =================================================================
    // read data path, enable registered from read strobe low, so it follows one cycle late
    logic [7:0] ident_byte;
    logic [7:0] next_data_out;
    logic       next_data_oe;

    // pick the ident value; version msb is pinned high
    always_comb begin
        case (sel)
            SEL_MAKER:   ident_byte = MAKER_IDENT;
            SEL_VERSION: ident_byte = {VERSION_IDENT_MSB_VAL,
                                       VERSION_IDENT};
            SEL_DRIVER:  ident_byte = DRIVER_IDENT;
            default:     ident_byte = DUMMY_BYTE;
        endcase
    end

    // dummy byte first, ident byte second
    always_comb begin
        next_data_oe  = ~host.rd_n;
        next_data_out = (state == ST_IDENT) ? ident_byte : DUMMY_BYTE;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_out <= DATA_OUT_RESET;
            data_oe  <= 1'b0;
        end else begin
            data_out <= next_data_out;
            data_oe  <= next_data_oe;
        end
    end

    // =================================================================
    // oscillator source select; external feed is on oscillator_pad
    logic next_offchip_osc_sel;

    // b0h/b1h switch, soft reset restores on-chip source
    always_comb begin
        next_offchip_osc_sel = offchip_osc_sel;
        if (cmd_take) begin
            case (cmd)
                SELECT_ONCHIP_OSC_CMD:  next_offchip_osc_sel = 1'b0;
                SELECT_OFFCHIP_OSC_CMD: next_offchip_osc_sel = 1'b1;
                CMD_SOFT_RESET: begin
                    next_offchip_osc_sel = OFFCHIP_OSC_RESET;
                end
                default:        next_offchip_osc_sel = offchip_osc_sel;
            endcase
        end
    end

    // hardware reset gives on-chip source
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            offchip_osc_sel <= OFFCHIP_OSC_RESET;
        end else begin
            offchip_osc_sel <= next_offchip_osc_sel;
        end
    end

    // =================================================================
    // checks
    a_maker_cmd_seq: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cmd_take && cmd == READ_MAKER_IDENT_CMD) |=>
            (state == ST_DUMMY && sel == SEL_MAKER))
        else $error("maker ident command not armed");

    a_maker_value: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_IDENT && sel == SEL_MAKER) |=>
            (data_out == MAKER_IDENT))
        else $error("maker ident byte wrong");

    a_version_msb_one: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_IDENT && sel == SEL_VERSION) |=>
            (data_out[VERSION_IDENT_MSB] == 1'b1 &&
             data_out[6:0] == VERSION_IDENT))
        else $error("version ident byte wrong");

    a_version_in_range: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_IDENT && sel == SEL_VERSION) |=>
            (data_out >= VERSION_RANGE_LOW))
        else $error("version ident below upper half");

    a_driver_value: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_IDENT && sel == SEL_DRIVER) |=>
            (data_out == DRIVER_IDENT))
        else $error("driver ident byte wrong");

    a_dummy_first: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_DUMMY && !cmd_take && rd_rise) |=>
            (state == ST_IDENT && $past(data_out) == DUMMY_BYTE))
        else $error("dummy read did not advance");

    a_dummy_byte: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_DUMMY) |=> (data_out == DUMMY_BYTE))
        else $error("dummy byte not driven");

    a_onchip_select: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cmd_take && cmd == SELECT_ONCHIP_OSC_CMD) |=> !offchip_osc_sel)
        else $error("on-chip oscillator not selected");

    a_offchip_select: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cmd_take && cmd == SELECT_OFFCHIP_OSC_CMD) |=> offchip_osc_sel)
        else $error("external oscillator not selected");

    a_reset_onchip: assert property (
        @(posedge sys_clk)
        (rst || (cmd_take && cmd == CMD_SOFT_RESET)) |=> !offchip_osc_sel)
        else $error("reset did not restore on-chip oscillator");

    a_read_drive: assert property (
        @(posedge sys_clk) disable iff (rst)
        !host.rd_n |=> data_oe)
        else $error("read data not driven");

endmodule

// File: iraos_host.sv
`timescale 1ns/1ns
// =====================================================================
// host processor model: command writes and read strobes
module iraos_host (
    input  wire logic              sys_clk,
    input  wire logic [7:0]        data_out,
    input  wire logic              data_oe,
    input  wire logic              offchip_osc_sel,
    output iraos_pkg::iraos_bus_s  host
);
    import iraos_pkg::*;

    logic [7:0] last_read;
    logic       oscillator_pad;

    // strobes idle high from time zero
    initial begin
        host = '{1'b1, 1'b1, 1'b1, 8'h00};
        last_read = 8'h00;
        oscillator_pad = 1'b0;
    end

    // external clock fed to the pad only while the device selects it
    always @(posedge sys_clk) begin
        oscillator_pad <= offchip_osc_sel ? ~oscillator_pad : 1'b0;
    end

    // one byte per write strobe, data held through the rising edge
    task automatic put(input logic dc, input logic [7:0] b, input int gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        host <= '{dc, 1'b0, 1'b1, b};
        @(posedge sys_clk);
        host.wr_n <= 1'b1;
        @(posedge sys_clk);
        host.data <= ~b; // released bus never keeps the old byte
    endtask

    // first read after a command is taken and thrown away
    task automatic rd(input int gap);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        host.rd_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        last_read = data_out;
        host.rd_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule

// File: test_id_read_and_osc_select.sv
`timescale 1ns/1ns
// =====================================================================
// self-checking bench for the ident read / osc select slice
module test_id_read_and_osc_select;
    import iraos_pkg::*;

    // arbitrary identity values for this run
    localparam logic [7:0] MAKER = 8'h96;
    localparam logic [6:0] VER   = 7'h0b;
    localparam logic [7:0] DRV   = 8'he7;

    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    iraos_bus_s host;
    logic [7:0] data_out;
    logic       data_oe;
    logic       offchip_osc_sel;
    logic       prev_oe = 1'b0;
    logic [7:0] exp_q[$];
    int         num_errors = 0;
    int         num_checks = 0;
    logic [7:0] cmds[3] = '{READ_MAKER_IDENT_CMD, READ_VERSION_IDENT_CMD,
                            READ_DRIVER_IDENT_CMD};
    logic [7:0] ids[3] = '{MAKER, {VERSION_IDENT_MSB_VAL, VER}, DRV};

    always #20 sys_clk = ~sys_clk;

    iraos_ident_osc #(
        .MAKER_IDENT   (MAKER),
        .VERSION_IDENT (VER),
        .DRIVER_IDENT  (DRV)
    ) iraos_ident_osc_i (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .host            (host),
        .data_out        (data_out),
        .data_oe         (data_oe),
        .offchip_osc_sel (offchip_osc_sel)
    );

    iraos_host iraos_host_i (
        .sys_clk  (sys_clk),
        .data_out (data_out),
        .data_oe  (data_oe),
        .offchip_osc_sel (offchip_osc_sel),
        .host     (host)
    );

    // =================================================================
    // helpers
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic int gap();
        return $urandom_range(0, 3);
    endfunction

    task automatic note_rd(input logic [7:0] e);
        exp_q.push_back(e);
        iraos_host_i.rd(gap());
        chk("data_oe", 8'h00, 8'(data_oe));
    endtask

    task automatic id_seq(input int k);
        iraos_host_i.put(1'b0, cmds[k], gap());
        note_rd(DUMMY_BYTE);
        note_rd(ids[k]);
    endtask

    task automatic osc(input logic [7:0] c, input logic e);
        iraos_host_i.put(1'b0, c, gap());
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("offchip_osc_sel", {7'h00, e}, {7'h00, offchip_osc_sel});
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // =================================================================
    // monitor: each new read answer is matched to the oldest note
    always @(negedge sys_clk) begin
        if (data_oe === 1'b1 && prev_oe !== 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("[ERR] data_out expected none seen %h", data_out);
            end else begin
                chk("data_out", exp_q.pop_front(), data_out);
            end
        end
        prev_oe = data_oe;
    end

    // watchdog
    initial begin
        #(40 * 5000);
        num_errors++;
        report_and_stop();
    end

    // =================================================================
    // main sequence
    initial begin
        void'($urandom(32'h8f0c8cb4));
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk("offchip_osc_sel", 8'h00, {7'h00, offchip_osc_sel});
        id_seq(0);
        id_seq(1);
        chk("version_msb", 8'h01, 8'(iraos_host_i.last_read[7]));
        id_seq(2);
        note_rd(DUMMY_BYTE);
        // data bytes between dummy and ident read are ignored
        iraos_host_i.put(1'b0, READ_MAKER_IDENT_CMD, gap());
        note_rd(DUMMY_BYTE);
        iraos_host_i.put(1'b1, 8'($urandom()), gap());
        note_rd(MAKER);
        // a new command restarts the sequence
        iraos_host_i.put(1'b0, READ_VERSION_IDENT_CMD, gap());
        id_seq(2);
        iraos_host_i.put(1'b0, 8'h10, gap());
        id_seq(0);
        osc(SELECT_OFFCHIP_OSC_CMD, 1'b1);
        osc(SELECT_ONCHIP_OSC_CMD, 1'b0);
        osc(SELECT_OFFCHIP_OSC_CMD, 1'b1);
        osc(CMD_SOFT_RESET, 1'b0);
        osc(SELECT_OFFCHIP_OSC_CMD, 1'b1);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk("offchip_osc_sel", 8'h00, {7'h00, offchip_osc_sel});
        id_seq(1);
        repeat (4) @(posedge sys_clk);
        chk("pending_notes", 8'h00, 8'(exp_q.size()));
        report_and_stop();
    end
endmodule
